// *** tzp_pkg.sv ***
// constants, types and carriers for the zone access-protection checker
// assumes the core supplies a matched entry and the mode/translation state

package tzp_pkg;

  localparam int unsigned TZP_ZONE_COUNT     = 16;
  localparam int unsigned TZP_ZONE_BITS      = 2;
  localparam int unsigned TZP_ZONE_SELECT_BITS      = 4;
  localparam int unsigned TZP_REG_BITS       = 32;
  localparam int unsigned TZP_TAG_BITS       = 8;
  localparam int unsigned TZP_SPR_BITS       = 10;
  localparam int unsigned TZP_REG_TOP        = 31;

  typedef logic [TZP_REG_BITS-1:0]  tzp_word_t;
  typedef logic [TZP_TAG_BITS-1:0]  tzp_tag_t;
  typedef logic [TZP_ZONE_SELECT_BITS-1:0] tzp_zone_select_t;
  typedef logic [TZP_ZONE_BITS-1:0] tzp_zone_t;
  typedef logic [TZP_SPR_BITS-1:0]  tzp_spr_t;

  // special register number of zone_override_control
  localparam tzp_spr_t  TZP_SPR_ZONE_OVERRIDE = 10'h3b0;
  localparam tzp_word_t TZP_ZONE_RESET        = 32'h0000_0000;
  localparam tzp_tag_t  TZP_GLOBAL_TAG        = 8'h00;

  // zone field encodings
  localparam tzp_zone_t TZP_ZONE_NONE   = 2'h0;
  localparam tzp_zone_t TZP_ZONE_PLAIN1 = 2'h1;
  localparam tzp_zone_t TZP_ZONE_MID    = 2'h2;
  localparam tzp_zone_t TZP_ZONE_FULL   = 2'h3;

  typedef enum logic [1:0] {
    TZP_ACC_FETCH = 2'b00,
    TZP_ACC_EXEC  = 2'b01,
    TZP_ACC_LOAD  = 2'b10,
    TZP_ACC_STORE = 2'b11
  } tzp_acc_e;

  // one check request from the core
  typedef struct packed {
    logic     valid;
    tzp_acc_e kind;
    logic     userMode;
    logic     instrXlateOn;
    logic     dataXlateOn;
    tzp_tag_t processId;
    logic     entryValid;
    tzp_tag_t entryProcessTag;
    tzp_zone_select_t zoneSelect;
    logic     executePermit;
    logic     writePermit;
  } tzp_req_s;

  // registered verdict
  typedef struct packed {
    logic     done;
    tzp_acc_e kind;
    logic     hit;
    logic     miss;
    logic     allow;
    logic     suppress;
    logic     fetchProtectionFault;
    logic     dataStorageFault;
    logic     fetchMarkedDenied;
    logic     effWritable;
    logic     effExecutable;
    tzp_zone_t zoneValue;
  } tzp_res_s;

  // special-register move from the core
  typedef struct packed {
    logic      valid;
    logic      write;
    logic      userMode;
    tzp_spr_t  number;
    tzp_word_t wdata;
  } tzp_spr_req_s;

  typedef struct packed {
    logic      ack;
    logic      privFault;
    tzp_word_t rdata;
  } tzp_spr_res_s;

endpackage

// *** tzp_zone_protect.sv ***
// zone and page access-protection checker with zone_override_control register
// assumes a matched entry is presented by the core; lookup itself lives elsewhere
// What this block does
// - use entries whose tag equals process id
// - tag zero entries match any process
// - execute only with execute permit set or a forcing zone
// - fetch fault only when instruction executes
// - writes need write permit or a forcing zone, else data fault
// - entries never block reads; privileged always reads
// - register holds sixteen two-bit zone fields
// - zone select picks zone number directly
// - zone 0 at msb pair, 15 lsb
// - user zone 00 denies every access
// - listed values leave entry bits unchanged
// - listed values force writable and executable
// - zone change acts at once on pages
// - register only privileged, special register 944
// - no protection fault with translation off
// - process id zero hits only tag zero
`timescale 1ns/1ps

module tzp_zone_protect
  import tzp_pkg::*;
#(
  parameter tzp_pkg::tzp_word_t ZONE_RESET = tzp_pkg::TZP_ZONE_RESET
)
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire tzp_pkg::tzp_req_s     chkReq,
  input  wire tzp_pkg::tzp_spr_req_s sprReq,
  output tzp_pkg::tzp_res_s          chkRes,
  output tzp_pkg::tzp_spr_res_s      sprRes,
  output tzp_pkg::tzp_word_t         zoneOverrideControl
);
  import tzp_pkg::*;

  typedef struct packed {
    tzp_word_t    zoneReg;
    tzp_res_s     res;
    tzp_spr_res_s spr;
  } tzp_state_s;

  tzp_state_s state;
  tzp_state_s next_state;

  // msb-first numbering: zone n sits at vector bits [31-2n -: 2]
  function automatic tzp_zone_t zoneOf(input tzp_word_t zr, input tzp_zone_select_t sel);
    tzp_zone_t z;
    int unsigned top;
    top = TZP_REG_TOP - TZP_ZONE_BITS * int'(sel);
    z = zr[top -: TZP_ZONE_BITS];
    return z;
  endfunction

  // process match; pid zero falls out since only tag zero equals it
  function automatic logic tagMatch(input tzp_tag_t tag, input tzp_tag_t process_id);
    return (tag == TZP_GLOBAL_TAG) || (tag == process_id);
  endfunction

  tzp_zone_t zoneVal;
  logic      isInstr;
  logic      xlateOn;
  logic      entryHit;
  logic      noAccess;
  logic      forceWx;
  logic      canWrite;
  logic      canExec;
  logic      denied;
  logic      sprHitReg;

  always_comb
  begin
    next_state = state;
    // live register read: no copy in the entries, so a field write acts at once
    zoneVal  = zoneOf(state.zoneReg, chkReq.zoneSelect);
    isInstr  = (chkReq.kind == TZP_ACC_FETCH) || (chkReq.kind == TZP_ACC_EXEC);
    xlateOn  = isInstr ? chkReq.instrXlateOn : chkReq.dataXlateOn;
    entryHit = chkReq.entryValid && tagMatch(chkReq.entryProcessTag, chkReq.processId);
    noAccess = chkReq.userMode && (zoneVal == TZP_ZONE_NONE);
    // user: only 11 forces; privileged: 10 and 11 force
    forceWx  = (zoneVal == TZP_ZONE_FULL) ||
               (!chkReq.userMode && (zoneVal == TZP_ZONE_MID));
    // remaining codes keep the entry's own bits
    canWrite = forceWx || chkReq.writePermit;
    canExec  = forceWx || chkReq.executePermit;
    denied   = 1'b0;
    unique case (chkReq.kind)
      TZP_ACC_FETCH: denied = noAccess || !canExec;
      TZP_ACC_EXEC:  denied = noAccess || !canExec;
      TZP_ACC_LOAD:  denied = noAccess;
      TZP_ACC_STORE: denied = noAccess || !canWrite;
    endcase

    next_state.res.done                 = chkReq.valid;
    next_state.res.kind                 = chkReq.kind;
    next_state.res.zoneValue            = zoneVal;
    next_state.res.effWritable          = canWrite;
    next_state.res.effExecutable        = canExec;
    next_state.res.hit                  = 1'b0;
    next_state.res.miss                 = 1'b0;
    next_state.res.allow                = 1'b0;
    next_state.res.suppress             = 1'b0;
    next_state.res.fetchProtectionFault = 1'b0;
    next_state.res.dataStorageFault     = 1'b0;
    next_state.res.fetchMarkedDenied    = 1'b0;
    if (chkReq.valid)
    begin
      if (!xlateOn)
      begin
        // real mode: no lookup, no protection
        next_state.res.allow = 1'b1;
      end
      else if (!entryHit)
      begin
        next_state.res.miss     = 1'b1;
        next_state.res.suppress = 1'b1;
      end
      else
      begin
        next_state.res.hit = 1'b1;
        if (!denied)
        begin
          next_state.res.allow = 1'b1;
        end
        else if (chkReq.kind == TZP_ACC_FETCH)
        begin
          // speculative fetch only marks the word; a discarded fetch never faults
          next_state.res.allow             = 1'b1;
          next_state.res.fetchMarkedDenied = 1'b1;
        end
        else
        begin
          next_state.res.suppress = 1'b1;
          next_state.res.fetchProtectionFault = (chkReq.kind == TZP_ACC_EXEC);
          next_state.res.dataStorageFault     = (chkReq.kind != TZP_ACC_EXEC);
        end
      end
    end

    // special-register port; other numbers belong to other units, no answer
    sprHitReg              = sprReq.valid && (sprReq.number == TZP_SPR_ZONE_OVERRIDE);
    next_state.spr.ack       = sprHitReg;
    next_state.spr.privFault = sprHitReg && sprReq.userMode;
    next_state.spr.rdata     = '0;
    if (sprHitReg && !sprReq.userMode)
    begin
      if (sprReq.write)
      begin
        next_state.zoneReg = sprReq.wdata;
      end
      else
      begin
        next_state.spr.rdata = state.zoneReg;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state         <= '0;
      state.zoneReg <= ZONE_RESET;
    end
    else if (clkEn)
    begin
      state <= next_state;
    end
  end

  assign chkRes              = state.res;
  assign sprRes              = state.spr;
  assign zoneOverrideControl = state.zoneReg;

endmodule

// *** tzp_core_model.sv ***
// core-side model issuing special-register moves
// assumes the protection block answers on the same clock
`timescale 1ns/1ps
module tzp_core_model
(
  input  wire logic             core_clk,
  input  tzp_pkg::tzp_spr_res_s sprRes,
  output tzp_pkg::tzp_spr_req_s sprReq
);
  import tzp_pkg::*;
  initial sprReq = '0;
  // held to the taking edge; released lines show inverted data, not stale
  task automatic move(input logic wr, usr, input tzp_spr_t n, input tzp_word_t wd,
                      output logic ack, pf, output tzp_word_t rd);
    @(posedge core_clk);
    sprReq <= '{1'b1, wr, usr, n, wd};
    @(posedge core_clk);
    sprReq <= '{1'b0, 1'b0, 1'b0, ~n, ~wd};
    #1;
    {ack, pf, rd} = sprRes;
  endtask
endmodule

// *** tzp_zone_protect_props.sv ***
// assertions on the zone protection checker ports
// assumes a single core_clk domain with sync reset
`timescale 1ns/1ps
module tzp_zone_protect_props
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic                  clkEn,
  input wire tzp_pkg::tzp_req_s     chkReq,
  input wire tzp_pkg::tzp_spr_req_s sprReq,
  input wire tzp_pkg::tzp_res_s     chkRes,
  input wire tzp_pkg::tzp_spr_res_s sprRes,
  input wire tzp_pkg::tzp_word_t    zoneOverrideControl
);
  import tzp_pkg::*;
  tzp_zone_t zv;
  logic      go, hd, ps;
  // zone 0 sits in the top pair
  assign zv = zoneOverrideControl[TZP_REG_TOP - 2*chkReq.zoneSelect -: 2];
  assign go = clkEn && chkReq.valid;
  assign hd = go && chkReq.dataXlateOn && chkReq.entryValid && chkReq.entryProcessTag == chkReq.processId;
  assign ps = clkEn && sprReq.valid && sprReq.number == TZP_SPR_ZONE_OVERRIDE;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_done_pulse: assert property (go |=> chkRes.done) else $error("no verdict");
  a_user_noaccess: assert property (hd && chkReq.userMode && zv == TZP_ZONE_NONE && chkReq.kind == TZP_ACC_LOAD
    |=> chkRes.dataStorageFault && chkRes.suppress) else $error("read not denied");
  a_priv_read: assert property (go && !chkReq.userMode && chkReq.kind == TZP_ACC_LOAD
    |=> !chkRes.dataStorageFault) else $error("priv read denied");
  a_store_ro: assert property (hd && !chkReq.writePermit && zv == TZP_ZONE_PLAIN1 && chkReq.kind == TZP_ACC_STORE
    |=> chkRes.dataStorageFault) else $error("store allowed");
  a_fetch_defer: assert property (go && chkReq.kind == TZP_ACC_FETCH
    |=> !chkRes.fetchProtectionFault) else $error("fetch faulted");
  a_zone_force: assert property (go && zv == TZP_ZONE_FULL |=> chkRes.effExecutable && chkRes.effWritable)
    else $error("zone not forcing");
  a_spr_refuse: assert property (ps && sprReq.userMode |=> sprRes.privFault && $stable(zoneOverrideControl))
    else $error("user move taken");
  a_spr_write: assert property (ps && sprReq.write && !sprReq.userMode
    |=> zoneOverrideControl == $past(sprReq.wdata)) else $error("write lost");
endmodule
bind tzp_zone_protect tzp_zone_protect_props chk_u (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
  .chkReq(chkReq), .sprReq(sprReq), .chkRes(chkRes), .sprRes(sprRes), .zoneOverrideControl(zoneOverrideControl));

// *** tzp_zone_protect_tb.sv ***
// self-checking bench for the zone protection checker
// assumes tzp_core_model as the special-register master
`timescale 1ns/1ps
module tzp_zone_protect_tb;
  import tzp_pkg::*;
  logic         core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, ack, pf;
  tzp_req_s     chkReq = '0;
  tzp_spr_req_s sprReq;
  tzp_res_s     chkRes;
  tzp_spr_res_s sprRes;
  tzp_word_t    zoneOverrideControl, zreg = '0, rd;
  int           err_total = 0, cmp_count = 0, cycles = 0;
  always #5 core_clk = ~core_clk;
  tzp_zone_protect dut_u (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .chkReq(chkReq), .sprReq(sprReq),
    .chkRes(chkRes), .sprRes(sprRes), .zoneOverrideControl(zoneOverrideControl));
  tzp_core_model core_u (.core_clk(core_clk), .sprRes(sprRes), .sprReq(sprReq));
  task automatic end_sim();
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      end_sim();
    end
  end
  task automatic cmp(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // {kind, eff w, eff x, zone, done, hit, miss, fetch marked, allow, suppress, fetch fault, data fault}
  function automatic logic [13:0] expv(tzp_req_s q, tzp_word_t z);
    tzp_zone_t v = z[31 - 2*q.zoneSelect -: 2];
    logic f = v == 2'h3 || (!q.userMode && v == 2'h2);
    logic d = (q.userMode && v == 2'h0) || (q.kind == TZP_ACC_STORE && !(f || q.writePermit))
              || (!q.kind[1] && !(f || q.executePermit));
    logic [5:0] e = {q.kind, f || q.writePermit, f || q.executePermit, v};
    if (!(q.kind[1] ? q.dataXlateOn : q.instrXlateOn))
      return {e, 8'h88};
    if (!q.entryValid || (q.entryProcessTag != 8'h00 && q.entryProcessTag != q.processId))
      return {e, 8'ha4};
    if (q.kind == TZP_ACC_FETCH)
      return {e, 3'h6, d, 4'h8};
    return {e, 4'hc, !d, d, d && !q.kind[1], d && q.kind[1]};
  endfunction
  function automatic logic [13:0] gotv();
    return {chkRes.kind, chkRes.effWritable, chkRes.effExecutable, chkRes.zoneValue, chkRes.done, chkRes.hit,
            chkRes.miss, chkRes.fetchMarkedDenied, chkRes.allow, chkRes.suppress, chkRes.fetchProtectionFault,
            chkRes.dataStorageFault};
  endfunction
  task automatic doCheck(input tzp_req_s q);
    @(posedge core_clk);
    chkReq <= q;
    @(posedge core_clk);
    chkReq.valid <= 1'b0;
    #1;
    cmp({18'h0, gotv()}, {18'h0, expv(q, zreg)});
  endtask
  task automatic wreg(input tzp_word_t v);
    core_u.move(1'b1, 1'b0, TZP_SPR_ZONE_OVERRIDE, v, ack, pf, rd);
    zreg = v;
  endtask
  initial
  begin
    tzp_req_s q;
    void'($urandom(21));
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    cmp(zoneOverrideControl, TZP_ZONE_RESET);
    core_u.move(1'b1, 1'b1, TZP_SPR_ZONE_OVERRIDE, 32'hffff_ffff, ack, pf, rd);
    cmp({30'h0, ack, pf}, 32'h3);
    core_u.move(1'b0, 1'b0, 10'h3b1, 32'h0, ack, pf, rd);
    cmp({31'h0, ack}, 32'h0);
    wreg(32'h0010_0000);
    core_u.move(1'b0, 1'b0, TZP_SPR_ZONE_OVERRIDE, 32'h0, ack, pf, rd);
    cmp(rd, zreg);
    q = '{1'b1, TZP_ACC_STORE, 1'b1, 1'b1, 1'b1, 8'h21, 1'b1, 8'h21, 4'h5, 1'b0, 1'b0};
    doCheck(q);
    wreg(32'h0030_0000);
    doCheck(q);
    q.processId = 8'h00;
    doCheck(q);
    for (int i = 0; i < 400; i++)
    begin
      if (i % 25 == 0)
        wreg($urandom);
      q = tzp_req_s'(29'($urandom));
      q.valid = 1'b1;
      if (i[0])
        q.entryProcessTag = q.processId;
      doCheck(q);
    end
    // enable low: neither a check nor a register move may land
    @(posedge core_clk);
    clkEn <= 1'b0;
    chkReq <= q;
    core_u.move(1'b1, 1'b0, TZP_SPR_ZONE_OVERRIDE, ~zreg, ack, pf, rd);
    cmp({29'h0, ack, chkRes.done, zoneOverrideControl != zreg}, 32'h0);
    @(posedge core_clk);
    clkEn <= 1'b1;
    @(posedge core_clk);
    chkReq.valid <= 1'b0;
    #1;
    cmp({18'h0, gotv()}, {18'h0, expv(q, zreg)});
    // second reset in mid-run clears verdict and register
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    zreg = TZP_ZONE_RESET;
    #1;
    cmp({18'h0, gotv()}, 32'h0);
    cmp(zoneOverrideControl, TZP_ZONE_RESET);
    doCheck(q);
    end_sim();
  end
endmodule
